// [hdl/sdram_command_decode_and_byte_mask.sv]
// command decode, bank state, byte masked array access and read path
// assumes pins come from another timing domain; driven pins need a tristate pad
`timescale 1ns/1ps

module sdram_command_decode_and_byte_mask
    import sdram_front_pkg::*;
#(
    parameter int ARRAY_ROW_BITS = 4,
    parameter int PRE_CYCLES     = PRECHARGE_CYCLES
) (
    input  wire logic                   MCLK,
    input  wire logic                   RESET,
    input  wire logic                   CKE,
    input  wire logic                   CS_N,
    input  wire logic                   RAS_N,
    input  wire logic                   CAS_N,
    input  wire logic                   WE_N,
    input  wire logic [BANK_BITS-1:0]   BANK_SELECT_BITS,
    input  wire logic [ROW_BITS-1:0]    ADDR,
    input  wire logic [LANE_COUNT-1:0]  BYTE_MASK_LINES,
    input  wire logic [DATA_BITS-1:0]   DQ_IN,
    output logic      [DATA_BITS-1:0]   DQ_OUT,
    output logic      [LANE_COUNT-1:0]  DQ_OE,
    output logic      [BANK_COUNT-1:0]  BANK_OPEN
);

    // ************************************************************
    // local types and helpers
    // ************************************************************
    localparam int IDX_BITS  = BANK_BITS + ARRAY_ROW_BITS + COL_BITS;
    localparam int PIN_BITS  = 4 + BANK_BITS + ROW_BITS + LANE_COUNT + DATA_BITS;
    localparam int CNT_BITS  = $clog2(PRE_CYCLES + 1);

    typedef logic [IDX_BITS-1:0] index_type;

    function automatic command_type decode_command(
        input logic cs_n,
        input logic ras_n,
        input logic cas_n,
        input logic we_n
    );
        command_type c;
        c = CMD_OTHER;
        if (cs_n) begin
            c = CMD_NONE;
        end else if (!ras_n && cas_n && we_n) begin
            c = CMD_ROW_OPEN;
        end else if (!ras_n && cas_n && !we_n) begin
            c = CMD_PRECHARGE;
        end else if (ras_n && !cas_n) begin
            c = we_n ? CMD_READ : CMD_WRITE;
        end else if (ras_n && cas_n && we_n) begin
            c = CMD_NONE;
        end
        return c;
    endfunction : decode_command

    function automatic index_type array_index(
        input logic [BANK_BITS-1:0] bank,
        input logic [ROW_BITS-1:0]  row,
        input logic [COL_BITS-1:0]  col
    );
        return {bank, row[ARRAY_ROW_BITS-1:0], col};
    endfunction : array_index

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic [PIN_BITS-1:0] sync1_reg;
    logic [PIN_BITS-1:0] sync2_reg;
    wire  [PIN_BITS-1:0] pins_raw = {CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT_BITS,
                                     ADDR, BYTE_MASK_LINES, DQ_IN};

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sync1_reg <= {PIN_BITS{1'b1}};
            sync2_reg <= {PIN_BITS{1'b1}};
        end else if (CKE) begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // sampled pin fields
    // ************************************************************
    wire                   s_cs_n;
    wire                   s_ras_n;
    wire                   s_cas_n;
    wire                   s_we_n;
    wire [BANK_BITS-1:0]   s_bank;
    wire [ROW_BITS-1:0]    s_addr;
    wire [LANE_COUNT-1:0]  s_mask;
    wire [DATA_BITS-1:0]   s_data;

    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr, s_mask, s_data} = sync2_reg;

    wire command_type      cmd       = decode_command(s_cs_n, s_ras_n, s_cas_n, s_we_n);
    wire                   a10       = s_addr[AUTO_PRE_BIT];
    wire [COL_BITS-1:0]    s_col     = s_addr[COL_BITS-1:0];
    wire                   is_open   = (cmd == CMD_ROW_OPEN);
    wire                   is_pre    = (cmd == CMD_PRECHARGE);
    wire                   is_read   = (cmd == CMD_READ);
    wire                   is_write  = (cmd == CMD_WRITE);

    // ************************************************************
    // bank state
    // ************************************************************
    bank_state_type        bank_state_reg [BANK_COUNT];
    bank_state_type        bank_state_next[BANK_COUNT];
    logic [ROW_BITS-1:0]   open_row_reg   [BANK_COUNT];
    logic [CNT_BITS-1:0]   pre_count_reg  [BANK_COUNT];
    logic [CNT_BITS-1:0]   pre_count_next [BANK_COUNT];

    wire                   sel_active = (bank_state_reg[s_bank] == BANK_ACTIVE);
    wire                   col_ok     = (is_read || is_write) && sel_active;
    wire                   auto_pre   = col_ok && a10;
    wire index_type        access_idx = array_index(s_bank, open_row_reg[s_bank], s_col);

    always_comb begin
        for (int b = 0; b < BANK_COUNT; b++) begin
            logic hit;
            logic pre_hit;
            hit             = (s_bank == BANK_BITS'(b));
            pre_hit         = is_pre && (hit || a10);
            bank_state_next[b] = bank_state_reg[b];
            pre_count_next[b]  = pre_count_reg[b];
            case (bank_state_reg[b])
                BANK_IDLE: begin
                    if (is_open && hit) begin
                        bank_state_next[b] = BANK_ACTIVE;
                    end
                end
                BANK_ACTIVE: begin
                    if (pre_hit || (auto_pre && hit)) begin
                        bank_state_next[b] = BANK_PRECHARGING;
                        pre_count_next[b]  = CNT_BITS'(PRE_CYCLES);
                    end
                end
                BANK_PRECHARGING: begin
                    if (pre_count_reg[b] <= CNT_BITS'(1)) begin
                        bank_state_next[b] = BANK_IDLE;
                        pre_count_next[b]  = '0;
                    end else begin
                        pre_count_next[b]  = pre_count_reg[b] - CNT_BITS'(1);
                    end
                end
                default: begin
                    bank_state_next[b] = BANK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int b = 0; b < BANK_COUNT; b++) begin
                bank_state_reg[b] <= BANK_IDLE;
                pre_count_reg[b]  <= '0;
                open_row_reg[b]   <= '0;
            end
        end else if (CKE) begin
            for (int b = 0; b < BANK_COUNT; b++) begin
                bank_state_reg[b] <= bank_state_next[b];
                pre_count_reg[b]  <= pre_count_next[b];
                if (is_open && (s_bank == BANK_BITS'(b)) && bank_state_reg[b] == BANK_IDLE) begin
                    open_row_reg[b] <= s_addr;
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < BANK_COUNT; b++) begin
            BANK_OPEN[b] = (bank_state_reg[b] == BANK_ACTIVE);
        end
    end

    // ************************************************************
    // storage array with per byte write mask
    // ************************************************************
    logic [DATA_BITS-1:0]  mem [2**IDX_BITS];

    always_ff @(posedge MCLK) begin
        if (CKE && is_write && sel_active) begin
            for (int l = 0; l < LANE_COUNT; l++) begin
                if (!s_mask[l]) begin
                    mem[access_idx][l*8 +: 8] <= s_data[l*8 +: 8];
                end
            end
        end
    end

    // ************************************************************
    // read path: data and mask both delayed two edges
    // ************************************************************
    logic                  rd_valid_reg;
    index_type             rd_idx_reg;
    logic [LANE_COUNT-1:0] rd_mask_reg;
    logic [DATA_BITS-1:0]  dq_out_reg;
    logic [LANE_COUNT-1:0] dq_oe_reg;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            rd_valid_reg <= 1'b0;
            rd_idx_reg   <= '0;
            rd_mask_reg  <= '0;
        end else if (CKE) begin
            rd_valid_reg <= is_read && sel_active;
            rd_idx_reg   <= access_idx;
            rd_mask_reg  <= s_mask;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            dq_out_reg <= '0;
            dq_oe_reg  <= '0;
        end else if (CKE) begin
            dq_out_reg <= rd_valid_reg ? mem[rd_idx_reg] : '0;
            dq_oe_reg  <= {LANE_COUNT{rd_valid_reg}} & ~rd_mask_reg;
        end
    end

    assign DQ_OUT = dq_out_reg;
    assign DQ_OE  = dq_oe_reg;

endmodule : sdram_command_decode_and_byte_mask

// [hdl/sdram_front_pkg.sv]
// constants and types for the sdram command decode and byte mask front end
// assumes a single clock; all pin inputs except CKE and RESET are synchronised inside the core
//
// Overview of operation
// - ras, cas and we form the command code, captured every rising edge while CKE is high
// - cs and ras low, cas and we high: open the selected bank's row
// - cs, ras, we low, cas high: precharge bank, idle once precharge done
// - cs low, ras high, cas low: column access to selected bank
// - we sampled on the same edge picks read or write for a column access
// - byte masks act per lane, only in the cycle they are sampled
// - a mask sampled high puts that lane's output drivers in high impedance
// - write with mask high leaves that byte of the array unchanged
// - read with mask high suppresses that output byte two clocks later; the core does it four clocks later, two of them in the pin synchroniser
// - mask 3 bits 31..24, mask 2 23..16, mask 1 15..8, mask 0 7..0
// - data bus transfers happen on rising clock edges in both directions
// - chip select high means the cycle carries no command
// - activate takes 13-bit row; column access takes 9-bit column, a10 auto precharge
// - precharge with a10 high precharges all four banks
// - column access with we high is a read, with we low a write
package sdram_front_pkg;

    localparam int ROW_BITS         = 13;
    localparam int COL_BITS         = 9;
    localparam int BANK_BITS        = 2;
    localparam int BANK_COUNT       = 4;
    localparam int LANE_COUNT       = 4;
    localparam int DATA_BITS        = 32;
    localparam int AUTO_PRE_BIT     = 10;
    localparam int READ_LATENCY     = 2;
    localparam int PRECHARGE_CYCLES = 3;
    localparam int SYNC_STAGES      = 2;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_ROW_OPEN,
        CMD_PRECHARGE,
        CMD_READ,
        CMD_WRITE,
        CMD_OTHER
    } command_type;

    typedef enum logic [1:0] {
        BANK_IDLE,
        BANK_ACTIVE,
        BANK_PRECHARGING
    } bank_state_type;

endpackage : sdram_front_pkg

// [dv/sdram_ctrl_model.sv]
// controller-side model: drives command, mask and write data pins
// assumes the bench calls issue once for each clock
`timescale 1ns/1ps

module sdram_ctrl_model
    import sdram_front_pkg::*;
(
    input  wire logic              MCLK,
    output logic                   CS_N,
    output logic                   RAS_N,
    output logic                   CAS_N,
    output logic                   WE_N,
    output logic [BANK_BITS-1:0]   BANK_SELECT_BITS,
    output logic [ROW_BITS-1:0]    ADDR,
    output logic [LANE_COUNT-1:0]  BYTE_MASK_LINES,
    output logic [DATA_BITS-1:0]   DQ_IN
);
    // ****************************************
    // pin driving
    // ****************************************
    initial begin
        {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
        BANK_SELECT_BITS = 2'h0;
        ADDR = 13'h0;
        BYTE_MASK_LINES = 4'h0;
        DQ_IN = 32'h5a5a5a5a;
    end

    // code is cs, ras, cas, we; pins move only at the falling edge
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic [3:0] m, input logic [31:0] d);
        @(negedge MCLK);
        {CS_N, RAS_N, CAS_N, WE_N} = c;
        BANK_SELECT_BITS = b;
        ADDR = a;
        BYTE_MASK_LINES = m;
        DQ_IN = (c == 4'h4) ? d : ~DQ_IN;
    endtask : issue
endmodule : sdram_ctrl_model

// [dv/sdram_front_asserts.sv]
// port checker for the command decode and byte mask front end
// assumes CKE stays high
`timescale 1ns/1ps

module sdram_front_asserts
    import sdram_front_pkg::*;
(
    input wire logic                  MCLK,
    input wire logic                  RESET,
    input wire logic                  CS_N,
    input wire logic                  RAS_N,
    input wire logic                  CAS_N,
    input wire logic                  WE_N,
    input wire logic [BANK_BITS-1:0]  BANK_SELECT_BITS,
    input wire logic [ROW_BITS-1:0]   ADDR,
    input wire logic [LANE_COUNT-1:0] BYTE_MASK_LINES,
    input wire logic [DATA_BITS-1:0]  DQ_OUT,
    input wire logic [LANE_COUNT-1:0] DQ_OE,
    input wire logic [BANK_COUNT-1:0] BANK_OPEN
);
    // ****************************************
    // decode and properties
    // ****************************************
    wire logic act = !CS_N && !RAS_N && CAS_N && WE_N;
    wire logic pre = !CS_N && !RAS_N && CAS_N && !WE_N;
    wire logic col = !CS_N && RAS_N && !CAS_N;
    wire logic rd  = col && WE_N;
    logic [3:0] quiet_reg;
    always_ff @(posedge MCLK or posedge RESET)
        if (RESET) quiet_reg <= 4'h0;
        else if (pre || (col && ADDR[10])) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    rd_lanes_a: assert property (rd ##2 BANK_OPEN[$past(BANK_SELECT_BITS, 2)]
        |-> ##2 DQ_OE == ~$past(BYTE_MASK_LINES, 4)) else $error("read lane enables wrong");
    rd_closed_a: assert property (rd ##2 !BANK_OPEN[$past(BANK_SELECT_BITS, 2)]
        |-> ##2 DQ_OE == 4'h0) else $error("read of closed bank drove bus");
    idle_bus_a: assert property (!$past(rd, 4) |-> DQ_OE == 4'h0 && DQ_OUT == 32'h0)
        else $error("bus driven without read");
    wr_quiet_a: assert property (col && !WE_N |-> ##4 DQ_OE == 4'h0)
        else $error("write drove bus");
    open_cause_a: assert property ((BANK_OPEN & ~$past(BANK_OPEN)) != 4'h0
        |-> $past(act, 3) && BANK_OPEN == ($past(BANK_OPEN) | (4'h1 << $past(BANK_SELECT_BITS, 3))))
        else $error("bank opened without activation");
    act_opens_a: assert property (act && quiet_reg >= 4'h8 ##2 !BANK_OPEN[$past(BANK_SELECT_BITS, 2)]
        |=> BANK_OPEN[$past(BANK_SELECT_BITS, 3)]) else $error("activation did not open bank");
    pre_one_a: assert property (pre && !ADDR[10] |-> ##3 !BANK_OPEN[$past(BANK_SELECT_BITS, 3)])
        else $error("precharge left bank open");
    pre_all_a: assert property (pre && ADDR[10] |-> ##3 BANK_OPEN == 4'h0)
        else $error("precharge all left a bank open");
    cover property (rd ##2 BANK_OPEN != 4'h0 ##2 DQ_OE != 4'hf);
    cover property (pre && ADDR[10] && BANK_OPEN != 4'h0);
    cover property (act ##3 BANK_OPEN != 4'h0);
endmodule : sdram_front_asserts

bind sdram_command_decode_and_byte_mask sdram_front_asserts u_chk (.MCLK, .RESET, .CS_N,
    .RAS_N, .CAS_N, .WE_N, .BANK_SELECT_BITS, .ADDR, .BYTE_MASK_LINES, .DQ_OUT, .DQ_OE, .BANK_OPEN);

// [dv/testbench.sv]
// self-checking bench: directed and random pin traffic against a bank model
// assumes the controller model owns every command and data pin
`timescale 1ns/1ps

module testbench
    import sdram_front_pkg::*;
;
    // ****************************************
    // bench
    // ****************************************
    typedef struct packed {logic [3:0] oe; logic [31:0] k; logic [31:0] d; logic [3:0] op;} exp_type;
    logic MCLK = 0, RESET = 1, cs_n, ras_n, cas_n, we_n;
    logic [1:0] bank;
    logic [12:0] addr, ra;
    logic [1:0] rb;
    logic [3:0] mask, dq_oe, bank_open, open_m = 0, c, arow [4] = '{default: 0};
    logic [31:0] dq_in, dq_out, mem [int];
    logic [3:0] known [int];
    int failures = 0, checks_done = 0, cyc = 0, ready [4] = '{default: 0};
    exp_type pipe [5], nxt = '0;
    always #2.5 MCLK = ~MCLK;
    sdram_ctrl_model u_ctl (.MCLK, .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .BANK_SELECT_BITS(bank), .ADDR(addr), .BYTE_MASK_LINES(mask), .DQ_IN(dq_in));
    sdram_command_decode_and_byte_mask u_dut (.MCLK, .RESET, .CKE(1'b1), .CS_N(cs_n),
        .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BANK_SELECT_BITS(bank), .ADDR(addr),
        .BYTE_MASK_LINES(mask), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .BANK_OPEN(bank_open));
    always @(posedge MCLK) begin
        pipe[0] <= nxt;
        for (int i = 1; i < 5; i++) pipe[i] <= pipe[i-1];
    end
    always @(negedge MCLK) if (!RESET) begin
        check("oe", 32'(dq_oe), 32'(pipe[3].oe));
        check("dq", dq_out & pipe[3].k, pipe[3].d);
        check("open", 32'(bank_open), 32'(pipe[2].op));
    end
    function automatic logic [31:0] lanes(input logic [3:0] m);
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction : lanes
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // drive one command and advance the bank and array model
    task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                        input logic [3:0] m, input logic [31:0] d);
        int k;
        k = {b, arow[b], a[8:0]};
        u_ctl.issue(c, b, a, m, d);
        nxt = '0;
        if (c == 4'h3 && !open_m[b] && cyc >= ready[b]) begin
            open_m[b] = 1'b1;
            arow[b] = a[3:0];
        end else if (c == 4'h2) begin
            for (int i = 0; i < 4; i++) if (a[10] || i == b) begin
                open_m[i] = 1'b0;
                ready[i] = cyc + 8;
            end
        end else if (c == 4'h4 && open_m[b]) begin
            if (!known.exists(k)) begin
                known[k] = 4'h0;
                mem[k] = 32'h0;
            end
            mem[k] = (mem[k] & lanes(m)) | (d & ~lanes(m));
            known[k] |= ~m;
        end else if (c == 4'h5 && open_m[b]) begin
            nxt.oe = ~m;
            nxt.k = known.exists(k) ? lanes(known[k] & ~m) : 32'h0;
            nxt.d = known.exists(k) ? mem[k] & nxt.k : 32'h0;
        end
        nxt.op = open_m;
        cyc++;
    endtask : step
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (3000) @(posedge MCLK);
        failures++;
        summarize();
    end
    initial begin
        void'($urandom(10));
        repeat (6) @(posedge MCLK);
        @(negedge MCLK) RESET = 0;
        step(4'h3, 1, 13'h1005, 0, 0);
        step(4'h4, 1, 2, 0, 32'h11223344);
        step(4'h4, 1, 2, 4'h5, 32'haabbccdd);
        step(4'h5, 1, 2, 0, 0);
        for (int i = 0; i < 4; i++) step(4'h5, 1, 2, 4'h1 << i, 0);
        step(4'h2, 1, 0, 0, 0);
        step(4'h3, 1, 0, 0, 0);
        step(4'h3, 0, 3, 0, 0);
        step(4'h3, 2, 4, 0, 0);
        step(4'h2, 3, 13'h0400, 0, 0);
        repeat (8) step(4'h7, 0, 0, 0, 0);
        $display("test directed done");
        repeat (600) begin
            c = 4'($urandom % 16);
            rb = 2'($urandom % 4);
            ra = 13'($urandom % 8192);
            if (c[2:1] == 2'b10) ra = 13'($urandom % 4);
            if (c == 4'h3 && cyc < ready[rb]) c = 4'h7;
            step(c, rb, ra, 4'($urandom % 16), $urandom);
        end
        repeat (6) step(4'h7, 0, 0, 0, 0);
        $display("test random done");
        summarize();
    end
endmodule : testbench
